// ===== rtl/ulock_top.sv
`timescale 1ns/1ns
`default_nettype none
module ulock_top
#(
	parameter int TICKS_PER_SECOND = ulock_pkg::TICKS_PER_SECOND,
	parameter int NUM_STAGES = ulock_pkg::NUM_STAGES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register port
	input wire ulock_pkg::ulock_bus_req_type bus_req_i,
	output logic [15:0] rdata_o,
	// lockout
	output logic usage_lockout_alarm_o,
	output logic [15:0] fault_code_o,
	// interrupt
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// address decoding

	function automatic logic is_stage_addr(input logic [7:0] addr);
		is_stage_addr = addr < (ulock_pkg::STAGE_BASE + 8'(2 * NUM_STAGES));
	endfunction

	function automatic int stage_of(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - ulock_pkg::STAGE_BASE;
		stage_of = int'(rel[7:1]);
	endfunction

	function automatic logic is_limit_addr(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - ulock_pkg::STAGE_BASE;
		is_limit_addr = rel[0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [15:0] password_r [NUM_STAGES];
	logic [15:0] limit_r [NUM_STAGES];
	logic [NUM_STAGES-1:0] unlocked_r;
	logic [NUM_STAGES-1:0] unlocked_nxt;
	logic [NUM_STAGES-1:0] pw_set;
	logic [NUM_STAGES-1:0] may_write;
	logic [NUM_STAGES-1:0] exceeded;
	logic [NUM_STAGES-1:0] limit_on;
	logic enable_r;
	logic alarm_nxt;
	logic [1:0] trip_stage_r;
	logic [1:0] trip_stage_nxt;
	logic [1:0] active_stage;
	logic active_valid;
	logic [ulock_pkg::IRQ_W-1:0] irq_status_r;
	logic [ulock_pkg::IRQ_W-1:0] irq_enable_r;
	logic [ulock_pkg::IRQ_W-1:0] irq_event;
	logic bad_password;
	logic [15:0] hours;
	logic [15:0] seconds;
	logic hour_tick;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [15:0] wdata;

	assign wr = bus_req_i.wr;
	assign rd = bus_req_i.rd;
	assign addr = bus_req_i.addr;
	assign wdata = bus_req_i.wdata;

	////////////////////////////////////////////////////////////////////////
	// usage time accumulator

	ulock_usage_timer #(
		.TICKS_PER_SECOND(TICKS_PER_SECOND)
	) u_timer (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.enable_i(enable_r),
		.hours_wr_i(wr && addr == ulock_pkg::HOURS_ADDR),
		.seconds_wr_i(wr && addr == ulock_pkg::SECONDS_ADDR),
		.wdata_i(wdata),
		.hours_o(hours),
		.seconds_o(seconds),
		.hour_tick_o(hour_tick)
	);

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			enable_r <= 1'b0;
		else if (wr && addr == ulock_pkg::CTRL_ADDR)
			enable_r <= wdata[ulock_pkg::CTRL_ENABLE_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// stage registers and password protection

	genvar g;
	generate
		for (g = 0; g < NUM_STAGES; g++)
		begin : g_stage
			assign pw_set[g] = password_r[g] != 16'h0000;
			assign may_write[g] = !pw_set[g] || unlocked_r[g];
			assign limit_on[g] = limit_r[g] != 16'h0000;
			assign exceeded[g] = limit_on[g] && (hours > limit_r[g]);

			always_ff @(posedge clk_i)
			begin
				if (reset_i)
					password_r[g] <= ulock_pkg::PASSWORD_RESET;
				else if (wr && is_stage_addr(addr) && stage_of(addr) == g && !is_limit_addr(addr)
					&& may_write[g])
					password_r[g] <= wdata;
			end

			// raising or zeroing the limit clears the alarm, as do lowering hours and disabling counting
			always_ff @(posedge clk_i)
			begin
				if (reset_i)
					limit_r[g] <= ulock_pkg::LIMIT_RESET;
				else if (wr && is_stage_addr(addr) && stage_of(addr) == g && is_limit_addr(addr)
					&& may_write[g])
					limit_r[g] <= wdata;
			end

			// entry opens only the stage whose set password it matches
			always_comb
			begin
				unlocked_nxt[g] = unlocked_r[g];
				if (wr && addr == ulock_pkg::UNLOCK_ADDR)
					unlocked_nxt[g] = pw_set[g] && (wdata == password_r[g]);
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			unlocked_r <= '0;
		else
			unlocked_r <= unlocked_nxt;
	end

	assign bad_password = wr && addr == ulock_pkg::UNLOCK_ADDR && (unlocked_nxt & pw_set) == '0;

	////////////////////////////////////////////////////////////////////////
	// lockout comparison

	// lowest tripped stage reported; lowest enabled stage is the active one
	always_comb
	begin
		alarm_nxt = |exceeded;
		trip_stage_nxt = 2'h0;
		active_stage = 2'h0;
		active_valid = 1'b0;
		for (int i = NUM_STAGES - 1; i >= 0; i--)
		begin
			if (exceeded[i])
				trip_stage_nxt = 2'(i);
			if (limit_on[i])
			begin
				active_stage = 2'(i);
				active_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			usage_lockout_alarm_o <= 1'b0;
		else
			usage_lockout_alarm_o <= alarm_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			fault_code_o <= 16'h0000;
		else
			fault_code_o <= alarm_nxt ? ulock_pkg::LOCKOUT_FAULT_CODE : 16'h0000;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			trip_stage_r <= 2'h0;
		else if (alarm_nxt)
			trip_stage_r <= trip_stage_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts

	always_comb
	begin
		irq_event = '0;
		irq_event[ulock_pkg::IRQ_ALARM_SET] = alarm_nxt && !usage_lockout_alarm_o;
		irq_event[ulock_pkg::IRQ_ALARM_CLEAR] = !alarm_nxt && usage_lockout_alarm_o;
		irq_event[ulock_pkg::IRQ_HOUR] = hour_tick;
		irq_event[ulock_pkg::IRQ_BAD_PASSWORD] = bad_password;
	end

	// set beats a clear landing in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			irq_status_r <= '0;
		else if (wr && addr == ulock_pkg::IRQ_CLEAR_ADDR)
			irq_status_r <= (irq_status_r & ~wdata[ulock_pkg::IRQ_W-1:0]) | irq_event;
		else
			irq_status_r <= irq_status_r | irq_event;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			irq_enable_r <= '0;
		else if (wr && addr == ulock_pkg::IRQ_ENABLE_ADDR)
			irq_enable_r <= wdata[ulock_pkg::IRQ_W-1:0];
	end

	assign irq_o = |(irq_status_r & irq_enable_r);

	////////////////////////////////////////////////////////////////////////
	// read port

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			rdata_o <= 16'h0000;
		else if (!rd)
			rdata_o <= 16'h0000;
		else if (is_stage_addr(addr) && is_limit_addr(addr))
			rdata_o <= limit_r[stage_of(addr)];
		else if (is_stage_addr(addr))
			rdata_o <= pw_set[stage_of(addr)] ? ulock_pkg::PASSWORD_SET_READ : 16'h0000;
		else if (addr == ulock_pkg::HOURS_ADDR)
			rdata_o <= hours;
		else if (addr == ulock_pkg::SECONDS_ADDR)
			rdata_o <= seconds;
		else if (addr == ulock_pkg::CTRL_ADDR)
			rdata_o <= 16'(enable_r) << ulock_pkg::CTRL_ENABLE_BIT;
		else if (addr == ulock_pkg::IRQ_STATUS_ADDR)
			rdata_o <= 16'(irq_status_r);
		else if (addr == ulock_pkg::IRQ_ENABLE_ADDR)
			rdata_o <= 16'(irq_enable_r);
		else if (addr == ulock_pkg::STATUS_ADDR)
		begin
			rdata_o <= (16'(usage_lockout_alarm_o) << ulock_pkg::STAT_ALARM_BIT)
				| (16'(trip_stage_r) << ulock_pkg::STAT_TRIP_LSB)
				| (16'(active_stage) << ulock_pkg::STAT_ACTIVE_LSB)
				| (16'(active_valid) << ulock_pkg::STAT_ACTIVE_VALID_BIT)
				| (16'(enable_r) << ulock_pkg::STAT_ENABLE_BIT)
				| (16'(unlocked_r) << ulock_pkg::STAT_UNLOCKED_LSB);
		end
		else if (addr == ulock_pkg::FAULT_ADDR)
			rdata_o <= fault_code_o;
		else
			rdata_o <= 16'h0000;
	end

endmodule
`default_nettype wire

// ===== include/ulock_pkg.sv
package ulock_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NUM_STAGES = 4;

	// register map, one 16-bit register per address
	localparam logic [7:0] STAGE_BASE = 8'h00;
	localparam logic [7:0] HOURS_ADDR = 8'h08;
	localparam logic [7:0] SECONDS_ADDR = 8'h09;
	localparam logic [7:0] CTRL_ADDR = 8'h0A;
	localparam logic [7:0] UNLOCK_ADDR = 8'h0B;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0C;
	localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h0D;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h0E;
	localparam logic [7:0] STATUS_ADDR = 8'h0F;
	localparam logic [7:0] FAULT_ADDR = 8'h10;

	// control and status fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int STAT_ALARM_BIT = 0;
	localparam int STAT_TRIP_LSB = 1;
	localparam int STAT_ACTIVE_LSB = 3;
	localparam int STAT_ACTIVE_VALID_BIT = 5;
	localparam int STAT_ENABLE_BIT = 6;
	localparam int STAT_UNLOCKED_LSB = 8;

	// interrupt causes
	localparam int IRQ_W = 4;
	localparam int IRQ_ALARM_SET = 0;
	localparam int IRQ_ALARM_CLEAR = 1;
	localparam int IRQ_HOUR = 2;
	localparam int IRQ_BAD_PASSWORD = 3;

	// reset values and constants
	localparam logic [15:0] PASSWORD_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [15:0] PASSWORD_SET_READ = 16'h0001;
	localparam logic [15:0] LOCKOUT_FAULT_CODE = 16'h0078;
	localparam logic [15:0] SECS_PER_HOUR = 16'h0E10;
	localparam logic [15:0] HOURS_MAX = 16'hFFFF;

	// timing
	localparam longint ONE_SECOND_NS = 1000000000;
	localparam longint CLK_PERIOD_NS = 4;
	localparam int TICKS_PER_SECOND = int'(ONE_SECOND_NS / CLK_PERIOD_NS);

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ulock_bus_req_type;

endpackage

// ===== rtl/ulock_usage_timer.sv
`timescale 1ns/1ns
`default_nettype none
module ulock_usage_timer
#(
	parameter int TICKS_PER_SECOND = ulock_pkg::TICKS_PER_SECOND
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// control
	input wire logic enable_i,
	input wire logic hours_wr_i,
	input wire logic seconds_wr_i,
	input wire logic [15:0] wdata_i,
	// counters
	output logic [15:0] hours_o,
	output logic [15:0] seconds_o,
	output logic hour_tick_o
);

	localparam int CW = $clog2(TICKS_PER_SECOND + 1);
	localparam logic [CW-1:0] TICK_LAST = CW'(TICKS_PER_SECOND - 1);

	logic [CW-1:0] tick_cnt_r;
	logic second_tick;
	logic hour_wrap;

	assign second_tick = enable_i && (tick_cnt_r == TICK_LAST);
	assign hour_wrap = second_tick && (seconds_o == ulock_pkg::SECS_PER_HOUR - 16'h0001);

	////////////////////////////////////////////////////////////////////////
	// own counters only; no link to lifetime power-on counters
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !enable_i || second_tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + CW'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i || !enable_i)
			seconds_o <= 16'h0000;
		else if (seconds_wr_i)
			seconds_o <= wdata_i;
		else if (hour_wrap)
			seconds_o <= 16'h0000;
		else if (second_tick)
			seconds_o <= seconds_o + 16'h0001;
	end

	// saturates rather than wrapping, a wrap would silently unlock
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !enable_i)
			hours_o <= 16'h0000;
		else if (hours_wr_i)
			hours_o <= wdata_i;
		else if (hour_wrap && hours_o != ulock_pkg::HOURS_MAX)
			hours_o <= hours_o + 16'h0001;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			hour_tick_o <= 1'b0;
		else
			hour_tick_o <= hour_wrap && !hours_wr_i;
	end

endmodule
`default_nettype wire

// ===== tb/ulock_props.sv
`timescale 1ns/1ns
`default_nettype none
module ulock_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// watched ports
	input wire ulock_pkg::ulock_bus_req_type bus_req_i,
	input wire logic [15:0] rdata_o,
	input wire logic usage_lockout_alarm_o,
	input wire logic [15:0] fault_code_o,
	input wire logic irq_o
);
	logic en_r;
	logic [3:0] ien_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// shadows of control and irq enable, so no internal probe is needed
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			en_r <= 1'b0;
			ien_r <= 4'h0;
		end
		else if (bus_req_i.wr && bus_req_i.addr == 8'h0A)
			en_r <= bus_req_i.wdata[0];
		else if (bus_req_i.wr && bus_req_i.addr == 8'h0E)
			ien_r <= bus_req_i.wdata[3:0];
	end
	////////////////////////////////////////////////
	rdata_idle_a: assert property (!bus_req_i.rd |=> rdata_o == 16'h0000)
		else $error("read data outside slot");
	fault_match_a: assert property (fault_code_o == (usage_lockout_alarm_o ? 16'h0078 : 16'h0000))
		else $error("fault code off");
	password_hide_a: assert property (bus_req_i.rd && bus_req_i.addr < 8'h08 && !bus_req_i.addr[0]
		|=> rdata_o <= 16'h0001) else $error("password shown");
	unmapped_read_a: assert property (bus_req_i.rd && bus_req_i.addr > 8'h10 |=> rdata_o == 16'h0000)
		else $error("unmapped read data");
	// counting off and no writes: nothing may move the alarm
	alarm_steady_a: assert property ((!en_r && !bus_req_i.wr)[*3] |=> $stable(usage_lockout_alarm_o))
		else $error("alarm moved");
	irq_on_alarm_a: assert property ($rose(usage_lockout_alarm_o) && ien_r[0] |-> irq_o)
		else $error("no irq on alarm");
	irq_masked_a: assert property (ien_r == 4'h0 |-> !irq_o)
		else $error("masked irq");
	fault_read_a: assert property (bus_req_i.rd && bus_req_i.addr == 8'h10 |=> rdata_o == $past(fault_code_o))
		else $error("fault read");
endmodule
bind ulock_top ulock_props props_i (.clk_i(clk_i), .reset_i(reset_i), .bus_req_i(bus_req_i), .rdata_o(rdata_o),
	.usage_lockout_alarm_o(usage_lockout_alarm_o), .fault_code_o(fault_code_o), .irq_o(irq_o));
`default_nettype wire

// ===== tb/test_usage_time_lockout.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h", $time, g); end end
module test_usage_time_lockout;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	ulock_pkg::ulock_bus_req_type req = '0;
	logic [15:0] rdata;
	logic alarm;
	logic [15:0] fault;
	logic irq;
	int fail_count = 0;
	int checks = 0;
	// short second keeps the hour rollover reachable
	ulock_top #(.TICKS_PER_SECOND(4), .NUM_STAGES(4)) dut (.clk_i(clk_i), .reset_i(reset_i), .bus_req_i(req),
		.rdata_o(rdata), .usage_lockout_alarm_o(alarm), .fault_code_o(fault), .irq_o(irq));
	always #2 clk_i = ~clk_i;
	////////////////////////////////////////////////
	task automatic acc(input logic [7:0] a, input logic [15:0] d, input logic w);
		@(posedge clk_i);
		req <= '{a, d, w, !w};
		@(posedge clk_i);
		req <= '0;
		#1;
	endtask
	// two spare edges: the alarm follows a write one cycle late
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		acc(a, d, 1'b1);
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		acc(a, 16'h0000, 1'b0);
		`CHK(rdata, e)
	endtask
	task automatic end_sim;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#40000;
		fail_count++;
		end_sim();
	end
	////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(8'h00, 16'h0000);
		rd(8'h01, 16'h0000);
		rd(8'h20, 16'h0000);
		`CHK(alarm, 1'b0)
		$display("test reset done");
		wr(8'h0E, 16'h000F);
		wr(8'h0A, 16'h0001);
		wr(8'h01, 16'h0005);
		wr(8'h03, 16'h0008);
		wr(8'h08, 16'h0005);
		`CHK(alarm, 1'b0)
		wr(8'h08, 16'h0006);
		`CHK(alarm, 1'b1)
		`CHK(irq, 1'b1)
		rd(8'h10, 16'h0078);
		$display("test trip done");
		wr(8'h00, 16'h1234);
		rd(8'h00, 16'h0001);
		wr(8'h01, 16'h0000);
		rd(8'h01, 16'h0005);
		wr(8'h0B, 16'h1111);
		rd(8'h0C, 16'h0009);
		wr(8'h0B, 16'h1234);
		wr(8'h01, 16'h0000);
		`CHK(alarm, 1'b0)
		rd(8'h01, 16'h0000);
		rd(8'h0F, 16'h0168);
		wr(8'h08, 16'h0009);
		`CHK(alarm, 1'b1)
		$display("test unlock done");
		wr(8'h0A, 16'h0000);
		rd(8'h08, 16'h0000);
		`CHK(alarm, 1'b0)
		wr(8'h0A, 16'h0001);
		wr(8'h08, 16'h0002);
		wr(8'h09, 16'h0E0E);
		repeat (12) @(posedge clk_i);
		rd(8'h08, 16'h0003);
		$display("test count done");
		wr(8'h0E, 16'h0000);
		`CHK(irq, 1'b0)
		wr(8'h0E, 16'h000F);
		`CHK(irq, 1'b1)
		rd(8'h0C, 16'h000F);
		wr(8'h0D, 16'h000F);
		rd(8'h0C, 16'h0000);
		`CHK(irq, 1'b0)
		$display("test irq done");
		end_sim();
	end
endmodule
`default_nettype wire
